// [src/eag_pkg.sv]
package eag_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] STEP_1 = 16'h0001;
  localparam logic [15:0] STEP_2 = 16'h0002;
  localparam logic [15:0] STEP_3 = 16'h0003;
  localparam int SYNC_STAGES = 2;

  // addressing mode of the instruction being formed
  typedef enum logic [2:0] {
    EAG_IX1 = 3'h0,
    EAG_IX2 = 3'h1,
    EAG_REL = 3'h3,
    EAG_BSC = 3'h2,
    EAG_BTB = 3'h6
  } eag_mode_t;

  // one instruction's operands, presented for one cycle
  typedef struct packed {
    eag_mode_t   mode;
    logic [2:0]  bit_num;
    logic        want_set;
    logic        cond;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [7:0]  index;
    logic [7:0]  tested_byte;
  } eag_req_t;

  // results of one instruction
  typedef struct packed {
    logic [15:0] effective_address;
    logic [15:0] tested_byte_address;
    logic [15:0] branch_target_address;
    logic [15:0] pc;
    logic [7:0]  bit_mask;
    logic        taken;
    logic        carry_valid;
    logic        carry;
  } eag_rsp_t;
endpackage

// [src/eag_rel_add.sv]
`timescale 1ns/1ps
module eag_rel_add
  import eag_pkg::*;
(
  input  wire logic [15:0] base,  // pc of the opcode
  input  wire logic [15:0] len,   // instruction length
  input  wire logic [7:0]  disp,  // signed displacement
  output wire logic [15:0] next,  // sequential address
  output wire logic [15:0] target // branch target
);
  // sign extension before the add, wraps at 16 bits
  assign next   = base + len;                        // RULE9
  assign target = next + {{8{disp[7]}}, disp};       // RULE9
endmodule

// [src/eag_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: short indexed adds index and operand byte, carry becomes high address byte, pc plus two.
// RULE2: long indexed adds index to the 16-bit operand with carry into the high byte, pc plus three.
// RULE3: relative branch adds the signed displacement to pc plus two only if taken, else pc plus two.
// RULE4: relative branch targets span 126 below to 129 above the opcode address.
// RULE5: bit set/clear uses the opcode bit number and a page-zero direct address, pc plus two.
// RULE6: bit test and branch reads the page-zero byte and branches from pc plus three on a match.
// RULE7: bit test and branch copies the tested bit into the carry flag, taken or not.
// RULE8: bit test and branch targets span 125 below to 130 above the opcode address.
// RULE9: pc arithmetic wraps at the address width with the displacement sign-extended.
module eag_top
  import eag_pkg::*;
(
  input  wire logic     sys_clk, // core clock
  input  wire logic     arst_n,  // async reset, active low
  input  wire logic     req_vld, // one-cycle request strobe
  input  wire eag_req_t req,     // operands for the request
  output eag_rsp_t      rsp,     // registered results
  output logic          rsp_vld  // one-cycle result strobe
);
  // reset release and the chained opcode address
  logic [SYNC_STAGES-1:0] rst_sync_r;    // reset release shift
  logic                   rst_n;         // synchronised reset
  logic [15:0]            pc_r;          // opcode address of the next request
  logic [15:0]            pc_nxt;        // pc_r after a request

  // next values of the answer fields
  logic                   mode_ok;       // known mode code
  logic [15:0]            new_pc;        // pc after a legal instruction
  logic [15:0]            ea_nxt;        // argument address
  logic [15:0]            tba_nxt;       // byte under test
  logic [15:0]            bta_nxt;       // branch target, taken or not
  logic [7:0]             mask_nxt;      // one-hot bit for the bit modes
  logic                   taken_nxt;     // branch goes
  logic                   carry_vld_nxt; // carry is written
  logic                   carry_nxt;     // copy of the tested bit

  // answer fields as shown on the port
  logic [15:0]            ea_r;          // argument address
  logic [15:0]            tba_r;         // tested byte address
  logic [15:0]            bta_r;         // branch target
  logic [7:0]             mask_r;        // bit mask
  logic                   taken_r;       // branch decision
  logic                   carry_vld_r;   // carry write
  logic                   carry_r;       // carry value

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) rst_sync_r <= '0;
    else rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], 1'b1};
  end
  assign rst_n = rst_sync_r[SYNC_STAGES-1];

  // answer struct is fixed at 16 address bits, and a single flop
  // of reset release could hand a metastable level to the datapath
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("eag_top needs a 16-bit address");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("eag_top needs two reset release flops");
  end

  // decoded mode strobes
  wire        is_ix1 = (req.mode == EAG_IX1);
  wire        is_ix2 = (req.mode == EAG_IX2);
  wire        is_rel = (req.mode == EAG_REL);
  wire        is_bsc = (req.mode == EAG_BSC);
  wire        is_btb = (req.mode == EAG_BTB);

  // short indexed: nine-bit sum, carry lands in bit 8
  wire [8:0]  ix1_sum = {1'b0, req.index} + {1'b0, req.op1};                 // RULE1
  wire [15:0] ix1_ea  = {7'h00, ix1_sum};                                    // RULE1
  // long indexed: low byte carry ripples into the high byte
  wire [8:0]  ix2_lo  = {1'b0, req.index} + {1'b0, req.op2};                 // RULE2
  wire [7:0]  ix2_hi  = req.op1 + {7'h00, ix2_lo[8]};                        // RULE2
  wire [15:0] ix2_ea  = {ix2_hi, ix2_lo[7:0]};                               // RULE2
  // page-zero direct address for both bit modes
  wire [15:0] dir_ea  = {8'h00, req.op1};                                    // RULE5 RULE6
  wire [7:0]  mask    = 8'h01 << req.bit_num;                                // RULE5
  wire        tbit    = req.tested_byte[req.bit_num];                        // RULE7
  wire        match   = (tbit == req.want_set);                              // RULE6

  // pc arithmetic shares one adder, length and displacement chosen by mode
  wire [15:0] len     = (is_ix2 || is_btb) ? STEP_3 : STEP_2;                // RULE2 RULE6
  wire [7:0]  disp    = is_btb ? req.op2 : req.op1;
  wire [15:0] seq_pc;
  wire [15:0] tgt_pc;

  eag_rel_add u_add (
    .base   (pc_r),
    .len    (len),
    .disp   (disp),
    .next   (seq_pc),
    .target (tgt_pc)
  );

  // span of -126..+129 and -125..+130 follows from the fixed lengths
  wire        taken   = (is_rel && req.cond) || (is_btb && match);           // RULE3 RULE4 RULE6 RULE8

  // legal codes; anything else answers with zeros
  assign mode_ok = is_ix1 | is_ix2 | is_rel | is_bsc | is_btb;

  // next pc: target only when the branch goes, else the next opcode
  assign new_pc = taken ? tgt_pc : seq_pc;                                   // RULE3 RULE6 RULE9

  // unknown code restarts from zero rather than run on from garbage
  assign pc_nxt = mode_ok ? new_pc : 16'h0000;

  // argument address on the bus; a relative branch shows where it goes
  assign ea_nxt = is_ix1 ? ix1_ea :                                          // RULE1
                  is_ix2 ? ix2_ea :                                          // RULE2
                  is_rel ? new_pc :                                          // RULE3
                  is_bsc ? dir_ea :                                          // RULE5
                  is_btb ? dir_ea :                                          // RULE6
                  16'h0000;

  // tested byte address exists only for bit test and branch
  assign tba_nxt = is_btb ? dir_ea : 16'h0000;                               // RULE6

  // target always formed, so untaken branches can be traced too
  assign bta_nxt = mode_ok ? tgt_pc : 16'h0000;                              // RULE9

  // both bit modes share the mask; the others leave it clear
  assign mask_nxt = (is_bsc || is_btb) ? mask : 8'h00;                       // RULE5

  // decision is already zero for non-branch and unknown codes
  assign taken_nxt = taken;                                                  // RULE3 RULE6

  // carry copy happens whether or not the branch goes
  assign carry_vld_nxt = is_btb;                                             // RULE7
  assign carry_nxt     = is_btb & tbit;                                      // RULE7

  // answer assembled from flops only, no logic behind the port
  assign rsp = '{
    effective_address:     ea_r,
    tested_byte_address:   tba_r,
    branch_target_address: bta_r,
    pc:                    pc_r,
    bit_mask:              mask_r,
    taken:                 taken_r,
    carry_valid:           carry_vld_r,
    carry:                 carry_r
  };

  // result strobe trails the request by exactly one edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_vld <= 1'b0;
    end else begin
      rsp_vld <= req_vld;
    end
  end

  // opcode address chains from one request to the next
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= PC_RST;
    end else if (req_vld) begin
      pc_r <= pc_nxt;                                                        // RULE9
    end
  end

  // argument address holds until the next request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_r <= '0;
    end else if (req_vld) begin
      ea_r <= ea_nxt;
    end
  end

  // tested byte address, zero outside bit test and branch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tba_r <= '0;
    end else if (req_vld) begin
      tba_r <= tba_nxt;
    end
  end

  // branch target kept even when the branch does not go
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bta_r <= '0;
    end else if (req_vld) begin
      bta_r <= bta_nxt;
    end
  end

  // bit mask for the read-modify-write of the bit modes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else if (req_vld) begin
      mask_r <= mask_nxt;
    end
  end

  // branch decision
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_r <= 1'b0;
    end else if (req_vld) begin
      taken_r <= taken_nxt;
    end
  end

  // carry write strobe, kept with the answer it belongs to
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_vld_r <= 1'b0;
    end else if (req_vld) begin
      carry_vld_r <= carry_vld_nxt;
    end
  end

  // carry level; stands so the core may latch it before the next request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_r <= 1'b0;
    end else if (req_vld) begin
      carry_r <= carry_nxt;
    end
  end
endmodule

// [verif/eag_mem.sv]
`timescale 1ns/1ps
module eag_mem
  import eag_pkg::*;
(
  input  wire logic [15:0] addr, // byte address on the bus
  output wire logic [7:0]  data  // byte read back
);
  // pattern folds in the high byte, so a non page-zero address reads other bits
  assign data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule

// [verif/eag_props.sv]
`timescale 1ns/1ps
module eag_props
  import eag_pkg::*;
(
  input wire logic     sys_clk, // core clock
  input wire logic     arst_n,  // async reset
  input wire logic     req_vld, // request strobe
  input wire eag_req_t req,     // request
  input wire eag_rsp_t rsp,     // results
  input wire logic     rsp_vld  // result strobe
);
  eag_req_t q_r; // request seen at the taking edge
  always_ff @(posedge sys_clk) q_r <= req;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // each result ties back to the operands of the request before it
  a_answer_follows: assert property (req_vld |=> rsp_vld) else $error("no answer");
  a_no_stray: assert property (!req_vld |=> !rsp_vld) else $error("stray answer");
  a_short_index: assert property (req_vld && req.mode == EAG_IX1 |=>
    rsp.effective_address == {8'h00, q_r.index} + {8'h00, q_r.op1}) else $error("ix1 sum");
  a_long_index: assert property (req_vld && req.mode == EAG_IX2 |=>
    rsp.effective_address == {q_r.op1, q_r.op2} + {8'h00, q_r.index}) else $error("ix2 sum");
  a_rel_target: assert property (req_vld && req.mode == EAG_REL && !req.cond |=>
    rsp.branch_target_address == rsp.pc + {{8{q_r.op1[7]}}, q_r.op1}) else $error("rel tgt");
  a_rel_taken: assert property (req_vld && req.mode == EAG_REL && req.cond |=>
    rsp.taken && rsp.pc == rsp.branch_target_address) else $error("rel taken");
  a_bsc_page: assert property (req_vld && req.mode == EAG_BSC |=>
    rsp.effective_address == {8'h00, q_r.op1}) else $error("bsc addr");
  a_btb_carry: assert property (req_vld && req.mode == EAG_BTB |=>
    rsp.carry_valid && rsp.carry == q_r.tested_byte[q_r.bit_num]) else $error("btb carry");
  a_btb_match: assert property (req_vld && req.mode == EAG_BTB |=>
    rsp.taken == (rsp.carry == q_r.want_set)) else $error("btb match");
endmodule
bind eag_top eag_props eag_props_i (.sys_clk(sys_clk), .arst_n(arst_n), .req_vld(req_vld),
  .req(req), .rsp(rsp), .rsp_vld(rsp_vld));

// [verif/eag_top_test.sv]
`timescale 1ns/1ps
module eag_top_test;
  import eag_pkg::*;
  logic sys_clk = 0, arst_n = 0, req_vld = 0, rsp_vld;
  logic [15:0] mem_a = 16'h0000, pc = 16'h0000;
  logic [7:0] mem_q;
  eag_req_t req = '0;
  eag_rsp_t rsp;
  int mismatches = 0, checked = 0;
  eag_top eag_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .req_vld(req_vld), .req(req),
    .rsp(rsp), .rsp_vld(rsp_vld));
  eag_mem eag_mem_i (.addr(mem_a), .data(mem_q));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // memory is addressed a cycle early so the read byte is settled at the request
  task automatic go(eag_mode_t m, logic c, logic w, logic [7:0] a, logic [7:0] b, logic [7:0] x);
    @(posedge sys_clk) mem_a <= {8'h00, a};
    @(posedge sys_clk) req_vld <= 1'b1;
    req <= '{m, 3'h5, w, c, a, b, x, mem_q};
    @(posedge sys_clk) req_vld <= 1'b0;
    #1 chk("rsp_vld", {15'h0, rsp_vld}, 16'h0001);
  endtask
  task automatic t_idx;
    go(EAG_IX1, 0, 0, 8'hff, 8'h00, 8'hff);
    pc = pc + 16'h0002;
    chk("ea_ix1", rsp.effective_address, 16'h01fe);
    chk("pc_ix1", rsp.pc, pc);
    go(EAG_IX2, 0, 0, 8'hff, 8'hf0, 8'h20);
    pc = pc + 16'h0003;
    chk("ea_ix2", rsp.effective_address, 16'h0010);
    chk("pc_ix2", rsp.pc, pc);
  endtask
  // backward branch from near zero wraps the address
  task automatic t_rel;
    go(EAG_REL, 1, 0, 8'h80, 8'h00, 8'h00);
    pc = pc - 16'h007e;
    chk("pc_rel_t", rsp.pc, pc);
    go(EAG_REL, 0, 0, 8'h7f, 8'h00, 8'h00);
    pc = pc + 16'h0002;
    chk("pc_rel_n", rsp.pc, pc);
    chk("bta_rel_n", rsp.branch_target_address, pc + 16'h007f);
    go(EAG_BSC, 0, 0, 8'ha5, 8'h00, 8'h00);
    pc = pc + 16'h0002;
    chk("ea_bsc", rsp.effective_address, 16'h00a5);
    chk("mask_bsc", {8'h00, rsp.bit_mask}, 16'h0020);
    chk("pc_bsc", rsp.pc, pc);
  endtask
  task automatic t_btb;
    for (int i = 0; i < 2; i++) begin
      go(EAG_BTB, 0, i[0], 8'h34, 8'h7f, 8'h00);
      pc = pc + ((mem_q[5] == i[0]) ? 16'h0082 : 16'h0003);
      chk("pc_btb", rsp.pc, pc);
      chk("carry", {15'h0, rsp.carry}, {15'h0, mem_q[5]});
      chk("carry_vld", {15'h0, rsp.carry_valid}, 16'h0001);
      chk("taken_btb", {15'h0, rsp.taken}, {15'h0, mem_q[5] == i[0]});
      chk("tba", rsp.tested_byte_address, 16'h0034);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_idx();
    t_rel();
    t_btb();
    stop_test();
  end
  // whole run is about forty cycles
  initial begin
    #4000 mismatches++;
    stop_test();
  end
endmodule
